// ### ssrb_status_bank.sv
`timescale 1ns/1ps
module ssrb_status_bank
  import ssrb_pkg::*;
(
  input  wire logic       clk_i,          // system clock 200 MHz
  input  wire logic       nrst_i,         // async reset, active low
  input  wire logic       rd_en_i,        // register read strobe
  input  wire logic [7:0] rd_index_i,     // register read index
  output logic      [7:0] rd_data_o,      // read data, registered
  output logic            rd_valid_o,     // read data valid pulse
  input  wire logic       wr_en_i,        // register write strobe
  input  wire logic [7:0] wr_index_i,     // register write index
  output logic            wr_ignored_o,   // write hit status group
  input  wire ssrb_evt_s  evt_i,          // pipeline events
  input  wire ssrb_win_s  win_i,          // window geometry
  input  wire ssrb_cal_s  cal_i,          // calibration pixels
  input  wire logic [1:0] dark_lines_i,   // 0:1 1:2 2:4 lines
  input  wire logic       black_lines_i,  // 0:4 1:8 lines
  input  wire logic [3:0] samples_log2_i  // pixels per line, log2
);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [NUM_PEND-1:0] pend_ff;      // update pending flags
  logic                odd_ff;       // odd/even frame
  logic [8:0]          line_cnt_ff;  // current line
  logic [8:0]          xend_ff;      // window x end
  logic [8:0]          yend_ff;      // window y end
  logic                xclip_ff;     // x clipped
  logic                yclip_ff;     // y clipped
  logic [11:0]         avg_ff [2];   // averages per channel
  logic [7:0]          update_pending_status;      // assembled update_pending_status
  logic [7:0]          nxt_rd_data;  // read mux output
  logic [9:0]          x_sum;        // unclamped x end + 1
  logic [9:0]          y_sum;        // unclamped y end + 1
  logic [3:0]          smp_log2;     // clamped sample count log2

  ////////////////////////////////////////////////////////////////////////////////
  // lines per average, log2, by channel
  function automatic logic [1:0] lines_log2(input int ch, input logic [1:0] dsel,
                                            input logic bsel);
    logic [1:0] r;
    r = 2'h0;
    if (ch == AVG_DARK) begin
      r = (dsel == 2'h3) ? 2'h2 : dsel;
    end else begin
      r = bsel ? 2'h3 : 2'h2;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pending flags: set by write, cleared only by apply; set wins
  genvar g;
  generate
    for (g = 0; g < NUM_PEND; g++) begin : g_pend
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pend_ff[g] <= PEND_RST[g];
        end else if (evt_i.param_write[g]) begin // RULE_04 RULE_05 RULE_06 RULE_07
          pend_ff[g] <= 1'b1;                    // RULE_09 RULE_10 RULE_11
        end else if (evt_i.param_apply[g]) begin // RULE_19
          pend_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // odd/even frame flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      odd_ff <= ODD_RST;
    end else if (evt_i.frame_start) begin
      odd_ff <= ~odd_ff; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line counter: cleared at frame start, counts line starts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_cnt_ff <= LINE_RST;
    end else if (evt_i.frame_start) begin
      line_cnt_ff <= LINE_RST;
    end else if (evt_i.line_start) begin
      line_cnt_ff <= line_cnt_ff + 9'h001; // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // window end coordinates, recomputed when pan/tilt applied
  assign x_sum = {1'b0, win_i.x_offset} + {1'b0, win_i.x_size};
  assign y_sum = {1'b0, win_i.y_offset} + {1'b0, win_i.y_size};

  // x end and clip flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      xend_ff  <= XEND_RST;
      xclip_ff <= 1'b0;
    end else if (evt_i.param_apply[PEND_PAN]) begin
      if (x_sum > {1'b0, XEND_MAX} + 10'h001) begin // window runs off array
        xend_ff  <= XEND_MAX;                      // RULE_13
        xclip_ff <= 1'b1;                          // RULE_17
      end else begin
        xend_ff  <= 9'(x_sum - 10'h001);           // RULE_13
        xclip_ff <= 1'b0;                          // RULE_17
      end
    end
  end

  // y end and clip flag
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      yend_ff  <= YEND_RST;
      yclip_ff <= 1'b0;
    end else if (evt_i.param_apply[PEND_TILT]) begin
      if (y_sum > {1'b0, YEND_MAX} + 10'h001) begin // window runs off array
        yend_ff  <= YEND_MAX;                      // RULE_14
        yclip_ff <= 1'b1;                          // RULE_18
      end else begin
        yend_ff  <= 9'(y_sum - 10'h001);           // RULE_14
        yclip_ff <= 1'b0;                          // RULE_18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dark and black averagers
  assign smp_log2 = (samples_log2_i > SAMPLES_LOG2_MAX) ? SAMPLES_LOG2_MAX : samples_log2_i;

  generate
    for (g = 0; g < 2; g++) begin : g_avg
      logic signed [AVG_ACC_W-1:0] acc_ff;   // running sum
      logic [8:0]                  pix_ff;   // pixels taken this line
      logic [3:0]                  lines_ff; // lines done
      logic [1:0]                  nl2;      // lines log2
      logic [3:0]                  nlines;   // lines per average
      logic [8:0]                  npix;     // pixels per line
      logic [4:0]                  shamt;    // divide shift
      logic signed [AVG_ACC_W-1:0] quot;     // shifted sum

      assign nl2    = lines_log2(g, dark_lines_i, black_lines_i);
      assign nlines = 4'h1 << nl2;
      assign npix   = 9'h001 << smp_log2;
      assign shamt  = {1'b0, smp_log2} + {3'h0, nl2};
      assign quot   = acc_ff >>> shamt;

      // accumulate, divide by shift once enough lines seen
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          acc_ff   <= '0;
          pix_ff   <= 9'h000;
          lines_ff <= 4'h0;
          avg_ff[g] <= AVG_RST;
        end else if (evt_i.frame_start) begin // restart every frame
          acc_ff   <= '0;
          pix_ff   <= 9'h000;
          lines_ff <= 4'h0;
        end else if (cal_i.line_end[g]) begin
          pix_ff <= 9'h000;
          if (lines_ff + 4'h1 == nlines) begin
            avg_ff[g] <= quot[11:0]; // RULE_15 RULE_16
            acc_ff    <= '0;
            lines_ff  <= 4'h0;
          end else begin
            lines_ff <= lines_ff + 4'h1;
          end
        end else if (cal_i.pix_valid[g] && pix_ff < npix) begin // cap samples per line
          acc_ff <= acc_ff + AVG_ACC_W'(cal_i.pix_data);        // RULE_15 RULE_16
          pix_ff <= pix_ff + 9'h001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // update_pending_status assembly
  always_comb begin
    update_pending_status                 = 8'h00;
    update_pending_status[ST0_FINE_BIT]   = pend_ff[PEND_FINE];
    update_pending_status[ST0_COARSE_BIT] = pend_ff[PEND_COARSE];
    update_pending_status[ST0_GAIN_BIT]   = pend_ff[PEND_GAIN];
    update_pending_status[ST0_CLKDIV_BIT] = pend_ff[PEND_CLKDIV];
    update_pending_status[ST0_ODD_BIT]    = odd_ff; // RULE_08
    update_pending_status[ST0_PAN_BIT]    = pend_ff[PEND_PAN];
    update_pending_status[ST0_TILT_BIT]   = pend_ff[PEND_TILT];
    update_pending_status[ST0_TIMING_BIT] = pend_ff[PEND_TIMING];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, side-effect free
  always_comb begin
    nxt_rd_data = 8'h00; // unused indices read zero
    case (rd_index_i)
      IDX_CHIP_ID_UPPER:          nxt_rd_data = CHIP_TYPE_CODE[11:4];          // RULE_01 RULE_02
      IDX_CHIP_ID_LOWER_REVISION: nxt_rd_data = {CHIP_TYPE_CODE[3:0], MASK_REV_CODE}; // RULE_03
      IDX_UPDATE_PENDING_STATUS:  nxt_rd_data = update_pending_status;
      IDX_LINE_COUNTER_UPPER:     nxt_rd_data = {7'h00, line_cnt_ff[8]};       // RULE_12
      IDX_LINE_COUNTER_LOWER:     nxt_rd_data = line_cnt_ff[7:0];              // RULE_12
      IDX_WINDOW_X_END_UPPER:     nxt_rd_data = {7'h00, xend_ff[8]};           // RULE_13
      IDX_WINDOW_X_END_LOWER:     nxt_rd_data = xend_ff[7:0];                  // RULE_13
      IDX_WINDOW_Y_END_UPPER:     nxt_rd_data = {7'h00, yend_ff[8]};           // RULE_14
      IDX_WINDOW_Y_END_LOWER:     nxt_rd_data = yend_ff[7:0];                  // RULE_14
      IDX_DARK_AVERAGE_UPPER:     nxt_rd_data = {4'h0, avg_ff[AVG_DARK][11:8]};  // RULE_15
      IDX_DARK_AVERAGE_LOWER:     nxt_rd_data = avg_ff[AVG_DARK][7:0];           // RULE_15
      IDX_BLACK_AVERAGE_UPPER:    nxt_rd_data = {4'h0, avg_ff[AVG_BLACK][11:8]}; // RULE_16
      IDX_BLACK_AVERAGE_LOWER:    nxt_rd_data = avg_ff[AVG_BLACK][7:0];          // RULE_16
      IDX_WINDOW_CLIP_STATUS:     nxt_rd_data = {6'h00, yclip_ff, xclip_ff};     // RULE_17 RULE_18
      default:                    nxt_rd_data = 8'h00;
    endcase
  end

  // registered read answer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= nxt_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writes to status group stored nowhere, only flagged
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ignored_o <= 1'b0;
    end else begin
      wr_ignored_o <= wr_en_i && (wr_index_i <= IDX_STATUS_LAST); // RULE_19
    end
  end

endmodule

// ### ssrb_pkg.sv
// Function
// RULE_01 - fixed 12-bit chip code, 4-bit revision
// RULE_02 - identity register 0 holds code upper byte
// RULE_03 - identity register 1: code low nibble, revision
// RULE_04 - update_pending_status bit0: fine exposure pending, reset 0
// RULE_05 - update_pending_status bit1: coarse exposure pending, reset 0
// RULE_06 - update_pending_status bit2: gain pending, reset 0
// RULE_07 - update_pending_status bit3: clock divisor pending, reset 0
// RULE_08 - update_pending_status bit4 toggles each frame, reset 1
// RULE_09 - update_pending_status bit5: pan parameters pending, reset 0
// RULE_10 - update_pending_status bit6: tilt parameters pending, reset 0
// RULE_11 - update_pending_status bit7: video timing pending, reset 0
// RULE_12 - 9-bit line count across two registers
// RULE_13 - window x end reported, reset 359
// RULE_14 - window y end reported, reset 293
// RULE_15 - signed 12-bit dark average, 1/2/4 lines
// RULE_16 - signed 12-bit black average, 4/8 lines
// RULE_17 - window_clip_status bit0: x window clipped, reset 0
// RULE_18 - window_clip_status bit1: y window clipped, reset 0
// RULE_19 - writes ignored, reads never alter flags
package ssrb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [7:0] IDX_CHIP_ID_UPPER          = 8'h00;
  localparam logic [7:0] IDX_CHIP_ID_LOWER_REVISION = 8'h01;
  localparam logic [7:0] IDX_UPDATE_PENDING_STATUS  = 8'h02;
  localparam logic [7:0] IDX_LINE_COUNTER_UPPER     = 8'h03;
  localparam logic [7:0] IDX_LINE_COUNTER_LOWER     = 8'h04;
  localparam logic [7:0] IDX_WINDOW_X_END_UPPER     = 8'h05;
  localparam logic [7:0] IDX_WINDOW_X_END_LOWER     = 8'h06;
  localparam logic [7:0] IDX_WINDOW_Y_END_UPPER     = 8'h07;
  localparam logic [7:0] IDX_WINDOW_Y_END_LOWER     = 8'h08;
  localparam logic [7:0] IDX_DARK_AVERAGE_UPPER     = 8'h09;
  localparam logic [7:0] IDX_DARK_AVERAGE_LOWER     = 8'h0A;
  localparam logic [7:0] IDX_BLACK_AVERAGE_UPPER    = 8'h0B;
  localparam logic [7:0] IDX_BLACK_AVERAGE_LOWER    = 8'h0C;
  localparam logic [7:0] IDX_WINDOW_CLIP_STATUS     = 8'h0D;
  localparam logic [7:0] IDX_STATUS_LAST            = 8'h0F; // end of status group

  ////////////////////////////////////////////////////////////////////////////////
  // identity (values arbitrary, not a real part)
  localparam logic [11:0] CHIP_TYPE_CODE = 12'h5C3; // arbitrary value
  localparam logic [3:0]  MASK_REV_CODE  = 4'h2;    // arbitrary value

  ////////////////////////////////////////////////////////////////////////////////
  // pending flag slots and their update_pending_status bit positions
  localparam int NUM_PEND       = 7;
  localparam int PEND_FINE      = 0;
  localparam int PEND_COARSE    = 1;
  localparam int PEND_GAIN      = 2;
  localparam int PEND_CLKDIV    = 3;
  localparam int PEND_PAN       = 4;
  localparam int PEND_TILT      = 5;
  localparam int PEND_TIMING    = 6;
  localparam int ST0_FINE_BIT   = 0;
  localparam int ST0_COARSE_BIT = 1;
  localparam int ST0_GAIN_BIT   = 2;
  localparam int ST0_CLKDIV_BIT = 3;
  localparam int ST0_ODD_BIT    = 4;
  localparam int ST0_PAN_BIT    = 5;
  localparam int ST0_TILT_BIT   = 6;
  localparam int ST0_TIMING_BIT = 7;
  localparam int ST1_XCLIP_BIT  = 0;
  localparam int ST1_YCLIP_BIT  = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [NUM_PEND-1:0] PEND_RST  = 7'h00;
  localparam logic                ODD_RST   = 1'b1;
  localparam logic [8:0]          XEND_RST  = 9'h167; // 359
  localparam logic [8:0]          YEND_RST  = 9'h125; // 293
  localparam logic [8:0]          XEND_MAX  = 9'h167; // largest legal x end
  localparam logic [8:0]          YEND_MAX  = 9'h125; // largest legal y end
  localparam logic [11:0]         AVG_RST   = 12'h000;
  localparam logic [8:0]          LINE_RST  = 9'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // averaging geometry
  localparam int AVG_ACC_W   = 23;   // 12 bits + 256 pixels + 8 lines
  localparam int AVG_DARK    = 0;    // channel index of dark lines
  localparam int AVG_BLACK   = 1;    // channel index of black lines
  localparam logic [3:0] SAMPLES_LOG2_MAX = 4'h8; // 256 pixels per line

  ////////////////////////////////////////////////////////////////////////////////
  // pipeline events, all one-cycle pulses
  typedef struct packed {
    logic [NUM_PEND-1:0] param_write; // host wrote a parameter
    logic [NUM_PEND-1:0] param_apply; // sensor took a parameter into use
    logic                frame_start; // first cycle of a frame
    logic                line_start;  // first cycle of a line
  } ssrb_evt_s;

  // calibration pixel stream
  typedef struct packed {
    logic [1:0]         pix_valid; // sample valid per channel
    logic [1:0]         line_end;  // calibration line finished per channel
    logic signed [11:0] pix_data;  // signed sample
  } ssrb_cal_s;

  // window geometry
  typedef struct packed {
    logic [8:0] x_offset; // programmed x start
    logic [8:0] x_size;   // requested width
    logic [8:0] y_offset; // programmed y start
    logic [8:0] y_size;   // requested height
  } ssrb_win_s;

endpackage

// ### ssrb_status_bank_props.sv
`timescale 1ns/1ps
module ssrb_status_bank_props
  import ssrb_pkg::*;
(
  input wire logic       clk_i,          // system clock
  input wire logic       nrst_i,         // async reset, active low
  input wire logic       rd_en_i,        // read strobe
  input wire logic [7:0] rd_index_i,     // read index
  input wire logic [7:0] rd_data_o,      // read data
  input wire logic       rd_valid_o,     // read valid pulse
  input wire logic       wr_en_i,        // write strobe
  input wire logic [7:0] wr_index_i,     // write index
  input wire logic       wr_ignored_o,   // write refused pulse
  input wire ssrb_evt_s  evt_i,          // pipeline events
  input wire ssrb_win_s  win_i,          // window geometry
  input wire ssrb_cal_s  cal_i,          // calibration pixels
  input wire logic [1:0] dark_lines_i,   // dark line count select
  input wire logic       black_lines_i,  // black line count select
  input wire logic [3:0] samples_log2_i  // pixels per line, log2
);
  ////////////////////////////////////////////////////////////////////////////////
  // one clock domain, reset disables all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // gain written, left alone a cycle, then status read
  sequence s_gain_wr_read;
    evt_i.param_write[PEND_GAIN] ##1 !evt_i.param_apply[PEND_GAIN]
      ##1 (rd_en_i && rd_index_i == IDX_UPDATE_PENDING_STATUS);
  endsequence
  // fine exposure applied alone, no rewrite, then status read
  sequence s_fine_apply_read;
    (evt_i.param_apply[PEND_FINE] && !evt_i.param_write[PEND_FINE])
      ##1 !evt_i.param_write[PEND_FINE]
      ##1 (rd_en_i && rd_index_i == IDX_UPDATE_PENDING_STATUS);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // read handshake and register contents
  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered next cycle");
  a_no_spurious: assert property (!rd_en_i |=> !rd_valid_o)
    else $error("read valid without a read");
  a_id_upper: assert property ((rd_en_i && rd_index_i == IDX_CHIP_ID_UPPER)
    |=> rd_data_o == CHIP_TYPE_CODE[11:4]) else $error("identity upper byte wrong");
  a_id_lower: assert property ((rd_en_i && rd_index_i == IDX_CHIP_ID_LOWER_REVISION)
    |=> rd_data_o == {CHIP_TYPE_CODE[3:0], MASK_REV_CODE}) else $error("identity lower wrong");
  a_gain_pending: assert property (s_gain_wr_read |=> rd_data_o[ST0_GAIN_BIT])
    else $error("gain pending flag not set");
  a_fine_cleared: assert property (s_fine_apply_read |=> !rd_data_o[ST0_FINE_BIT])
    else $error("fine pending flag not cleared");
  a_clip_unused: assert property ((rd_en_i && rd_index_i == IDX_WINDOW_CLIP_STATUS)
    |=> rd_data_o[7:2] == 6'h00) else $error("clip status unused bits set");
  a_line_upper: assert property ((rd_en_i && rd_index_i == IDX_LINE_COUNTER_UPPER)
    |=> rd_data_o[7:1] == 7'h00) else $error("line count upper has stray bits");
  a_write_refused: assert property ((wr_en_i && wr_index_i <= IDX_STATUS_LAST)
    |=> wr_ignored_o) else $error("write to status group not refused");
endmodule

bind ssrb_status_bank ssrb_status_bank_props chk_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .rd_en_i(rd_en_i), .rd_index_i(rd_index_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wr_en_i(wr_en_i),
  .wr_index_i(wr_index_i), .wr_ignored_o(wr_ignored_o), .evt_i(evt_i), .win_i(win_i),
  .cal_i(cal_i), .dark_lines_i(dark_lines_i), .black_lines_i(black_lines_i),
  .samples_log2_i(samples_log2_i));

// ### ssrb_host_model.sv
`timescale 1ns/1ps
module ssrb_host_model (
  input  wire logic       clk_i,        // system clock
  output logic            rd_en_o,      // read strobe
  output logic      [7:0] rd_index_o,   // read index
  output logic            wr_en_o,      // write strobe
  output logic      [7:0] wr_index_o,   // write index
  input  wire logic [7:0] rd_data_i,    // read data
  input  wire logic       rd_valid_i,   // read valid pulse
  input  wire logic       wr_ignored_i  // write refused pulse
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    rd_en_o = 1'b0;
    rd_index_o = 8'h00;
    wr_en_o = 1'b0;
    wr_index_o = 8'h00;
  end
  // one read; index inverted once released so stale values never match
  task read(input logic [7:0] idx, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    rd_en_o = 1'b1;
    rd_index_o = idx;
    @(posedge clk_i);
    @(negedge clk_i);
    rd_en_o = 1'b0;
    rd_index_o = ~idx;
    v = rd_valid_i;
    d = rd_data_i;
  endtask
  // one write; answer pulse taken a cycle later
  task write(input logic [7:0] idx, output logic ign);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_index_o = idx;
    @(posedge clk_i);
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_index_o = ~idx;
    ign = wr_ignored_i;
  endtask
endmodule

// ### test_sensor_status_register_bank.sv
`timescale 1ns/1ps
module test_sensor_status_register_bank;
  import ssrb_pkg::*;
  `define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
  logic       clk_i, nrst_i, rd_en, wr_en, rd_valid, wr_ignored, v;  // bench nets
  logic [7:0] rd_index, wr_index, rd_data, st;                       // bus values
  ssrb_evt_s  evt, e;                                                // event pulses
  ssrb_win_s  win;                                                   // window geometry
  ssrb_cal_s  cal;                                                   // pixel stream
  logic [1:0] dark_sel;                                              // dark line select
  logic       black_sel;                                             // black line select
  logic [3:0] smp_sel;                                               // samples per line log2
  int         n_errors, checks_done;                                 // tallies
  int         bitpos [7] = '{0, 1, 2, 3, 5, 6, 7};                   // slot to status bit

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  ssrb_status_bank dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .rd_en_i(rd_en), .rd_index_i(rd_index),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_en_i(wr_en), .wr_index_i(wr_index),
    .wr_ignored_o(wr_ignored), .evt_i(evt), .win_i(win), .cal_i(cal), .dark_lines_i(dark_sel),
    .black_lines_i(black_sel), .samples_log2_i(smp_sel));
  ssrb_host_model host_u (.clk_i(clk_i), .rd_en_o(rd_en), .rd_index_o(rd_index),
    .wr_en_o(wr_en), .wr_index_o(wr_index), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .wr_ignored_i(wr_ignored));

  ////////////////////////////////////////////////////////////////////////////////
  // read one register and compare
  task rd(input logic [7:0] idx, input logic [7:0] ex);
    logic [7:0] d;
    logic       ok;
    host_u.read(idx, d, ok);
    `CHK("read valid", 1'b1, ok)
    `CHK($sformatf("register %h", idx), ex, d)
  endtask
  // one-cycle event pulse
  task ev(input ssrb_evt_s x);
    @(negedge clk_i);
    evt = x;
    @(negedge clk_i);
    evt = '0;
  endtask
  // one-cycle calibration sample or line end
  task pix(input logic [1:0] pv, input logic [1:0] le, input logic [11:0] d);
    @(negedge clk_i);
    cal = '{pix_valid: pv, line_end: le, pix_data: d};
    @(negedge clk_i);
    cal = '0;
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    nrst_i = 1'b0;
    evt = '0;
    cal = '0;
    dark_sel = 2'h0;
    black_sel = 1'b0;
    smp_sel = 4'h2;
    n_errors = 0;
    checks_done = 0;
    win = '{x_offset: 9'h064, x_size: 9'h12C, y_offset: 9'h00A, y_size: 9'h032};
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    nrst_i = 1'b1;
    // identity and reset contents
    rd(IDX_CHIP_ID_UPPER, CHIP_TYPE_CODE[11:4]);
    rd(IDX_CHIP_ID_LOWER_REVISION, {CHIP_TYPE_CODE[3:0], MASK_REV_CODE});
    rd(IDX_UPDATE_PENDING_STATUS, 8'h10);
    rd(IDX_LINE_COUNTER_UPPER, 8'h00);
    rd(IDX_LINE_COUNTER_LOWER, 8'h00);
    rd(IDX_WINDOW_X_END_UPPER, 8'h01);
    rd(IDX_WINDOW_X_END_LOWER, 8'h67);
    rd(IDX_WINDOW_Y_END_UPPER, 8'h01);
    rd(IDX_WINDOW_Y_END_LOWER, 8'h25);
    for (int i = 9; i <= 12; i++) rd(i[7:0], 8'h00);
    rd(IDX_WINDOW_CLIP_STATUS, 8'h00);
    rd(8'h0E, 8'h00);
    // each pending flag set by a write, kept by reads, cleared by apply
    for (int k = 0; k < NUM_PEND; k++) begin
      e = '0;
      e.param_write[k] = 1'b1;
      ev(e);
      st = 8'h10 | (8'h01 << bitpos[k]);
      rd(IDX_UPDATE_PENDING_STATUS, st);
      rd(IDX_UPDATE_PENDING_STATUS, st);
      e = '0;
      e.param_apply[k] = 1'b1;
      ev(e);
      st = 8'h10;
      rd(IDX_UPDATE_PENDING_STATUS, st);
    end
    // write and apply together keep the flag; host write refused
    e = '0;
    e.param_write[PEND_GAIN] = 1'b1;
    e.param_apply[PEND_GAIN] = 1'b1;
    ev(e);
    host_u.write(IDX_UPDATE_PENDING_STATUS, v);
    `CHK("write refused", 1'b1, v)
    host_u.write(8'h10, v);
    `CHK("write outside group", 1'b0, v)
    rd(IDX_UPDATE_PENDING_STATUS, 8'h14);
    e = '0;
    e.param_apply[PEND_GAIN] = 1'b1;
    ev(e);
    rd(IDX_UPDATE_PENDING_STATUS, 8'h10);
    // frame toggle and line counting
    e = '0;
    e.frame_start = 1'b1;
    ev(e);
    rd(IDX_UPDATE_PENDING_STATUS, 8'h00);
    e = '0;
    e.line_start = 1'b1;
    repeat (3) ev(e);
    rd(IDX_LINE_COUNTER_LOWER, 8'h03);
    e = '0;
    e.frame_start = 1'b1;
    ev(e);
    rd(IDX_UPDATE_PENDING_STATUS, 8'h10);
    rd(IDX_LINE_COUNTER_LOWER, 8'h00);
    // window ends: x clipped to 359, y 10+50-1
    e = '0;
    e.param_apply[PEND_PAN] = 1'b1;
    e.param_apply[PEND_TILT] = 1'b1;
    ev(e);
    rd(IDX_WINDOW_X_END_LOWER, 8'h67);
    rd(IDX_WINDOW_Y_END_UPPER, 8'h00);
    rd(IDX_WINDOW_Y_END_LOWER, 8'h3B);
    rd(IDX_WINDOW_CLIP_STATUS, 8'h01);
    win.y_size = 9'h12C;
    e.param_apply[PEND_PAN] = 1'b0;
    ev(e);
    rd(IDX_WINDOW_Y_END_LOWER, 8'h25);
    rd(IDX_WINDOW_CLIP_STATUS, 8'h03);
    // dark: one line of four -8 samples, fifth sample beyond the cap dropped
    repeat (4) pix(2'b01, 2'b00, 12'hFF8);
    pix(2'b01, 2'b00, 12'h100);
    pix(2'b00, 2'b01, 12'h000);
    rd(IDX_DARK_AVERAGE_UPPER, 8'h0F);
    rd(IDX_DARK_AVERAGE_LOWER, 8'hF8);
    // black: four lines of four samples of 5
    repeat (4) begin
      repeat (4) pix(2'b10, 2'b00, 12'h005);
      pix(2'b00, 2'b10, 12'h000);
    end
    rd(IDX_BLACK_AVERAGE_UPPER, 8'h00);
    rd(IDX_BLACK_AVERAGE_LOWER, 8'h05);
    // dark 4 lines (select 3), black 8 lines, two of three -4 samples kept per line
    dark_sel = 2'h3;
    black_sel = 1'b1;
    smp_sel = 4'h1;
    for (int n = 1; n <= 8; n++) begin
      repeat (3) pix(2'b11, 2'b00, 12'hFFC);
      pix(2'b00, 2'b11, 12'h000);
      if (n == 2) rd(IDX_DARK_AVERAGE_LOWER, 8'hF8);
      if (n == 4) rd(IDX_DARK_AVERAGE_LOWER, 8'hFC);
      if (n == 4) rd(IDX_BLACK_AVERAGE_LOWER, 8'h05);
    end
    rd(IDX_BLACK_AVERAGE_UPPER, 8'h0F);
    rd(IDX_BLACK_AVERAGE_LOWER, 8'hFC);
    report_and_stop;
  end
endmodule
